// *** hw/status_led_pkg.sv ***
// Constants and types shared by the status indicator driver
package status_led_pkg;
    // Panel geometry
    localparam int LED_W = 16;
    // Common positions on both panels
    localparam int POS_RUN = 0;
    localparam int POS_HOST = 1;
    localparam int POS_FN_CMD = 2;
    localparam int POS_FAST = 3;
    localparam int POS_REMOTE = 4;
    // Positions on the 16-position panel
    localparam int WIDE_DEDICATED = 5;
    localparam int WIDE_FAULT = 7;
    localparam int WIDE_TX = 13;
    localparam int WIDE_RX = 14;
    localparam int WIDE_SPEED = 15;
    localparam logic [15:0] WIDE_DARK_MASK = 16'h1f40;
    // Positions on the 8-position panel
    localparam int NARROW_TX = 5;
    localparam int NARROW_RX = 6;
    localparam int NARROW_SPEED = 7;
    localparam logic [15:0] NARROW_DARK_MASK = 16'hff00;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int BLINK_HALF_MS = 50;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLINK_CNT_W = 23;
    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STRETCH = 8'h04;
    localparam logic [7:0] REG_FLAGS = 8'h08;
    localparam logic [7:0] REG_EVENTS = 8'h0c;
    localparam logic [7:0] REG_MASK = 8'h10;
    localparam logic [7:0] REG_LEDS = 8'h14;
    localparam int CTRL_NARROW_BIT = 0;
    localparam logic CTRL_RESET = 1'h0;
    localparam int STRETCH_W = 8;
    localparam logic [7:0] STRETCH_RESET = 8'h04;
    // Sticky event bits
    localparam int EVT_W = 4;
    localparam int EVT_FATAL = 0;
    localparam int EVT_HOST_LOST = 1;
    localparam int EVT_SPEED = 2;
    localparam int EVT_INIT = 3;
    localparam logic [3:0] EVT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam int FLAGS_W = 12;

    typedef struct packed {
        logic power_good;
        logic init_done;
        logic host_if_ok;
        logic fn_block_cmd_service;
        logic fast_link_service;
        logic remote_tool_service;
        logic dedicated_comm_service;
        logic operator_interface;
        logic fatal_error;
        logic tx_active;
        logic rx_active;
        logic speed_100;
    } status_flags_t;
endpackage

// *** hw/status_led_indicator.sv ***
// Front-panel status indicator driver with register port
// How it works
// - Position 0 is lit while power is good and initialisation is done, dark otherwise.
// - Position 1 is lit while the host CPU interface communicates normally.
// - Position 2 is lit once the function-block or command service has started.
// - Position 3 is lit once the fast link service has started.
// - On the wide panel position 4 is lit once the remote tool service has started.
// - On the wide panel position 5 is lit once the dedicated communication service has started.
// - On the narrow panel position 4 is lit when the remote tool or operator interface service runs.
// - On the wide panel position 7 is lit while the module has an unrecoverable fatal error.
// - The transmit indicator blinks while frames are sent, at 13 wide or 5 narrow.
// - The receive indicator blinks while frames are received, at 14 wide or 6 narrow.
// - The speed indicator shows 10 or 100 Mb/s, at 15 wide or 7 narrow.
`timescale 1ns/10ps
`default_nettype none

module status_led_indicator #(
    parameter int unsigned BLINK_HALF_CYCLES = status_led_pkg::BLINK_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire status_led_pkg::status_flags_t flags,
    input wire logic [status_led_pkg::ADDR_W-1:0] addr,
    input wire logic [status_led_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [status_led_pkg::DATA_W-1:0] rdata,
    output logic irq,
    output logic [status_led_pkg::LED_W-1:0] led
);

    // Retriggerable stretch counter
    function automatic logic [status_led_pkg::STRETCH_W-1:0] next_stretch(
        input logic act,
        input logic tick,
        input logic [status_led_pkg::STRETCH_W-1:0] cnt,
        input logic [status_led_pkg::STRETCH_W-1:0] len
    );
        if (act) begin
            return (len == '0) ? status_led_pkg::STRETCH_W'(1) : len;
        end
        if (tick && cnt != '0) begin
            return cnt - status_led_pkg::STRETCH_W'(1);
        end
        return cnt;
    endfunction

    // Blink phase, starts lit on a fresh burst
    function automatic logic next_phase(
        input logic act,
        input logic tick,
        input logic [status_led_pkg::STRETCH_W-1:0] cnt,
        input logic phase
    );
        if (cnt == '0) begin
            return act;
        end
        if (tick) begin
            return ~phase;
        end
        return phase;
    endfunction

    logic narrow;
    logic [status_led_pkg::STRETCH_W-1:0] stretch_len;
    logic [status_led_pkg::EVT_W-1:0] events;
    logic [status_led_pkg::EVT_W-1:0] mask;
    logic [status_led_pkg::BLINK_CNT_W-1:0] blink_cnt;
    logic [status_led_pkg::STRETCH_W-1:0] tx_cnt;
    logic [status_led_pkg::STRETCH_W-1:0] rx_cnt;
    logic tx_phase;
    logic rx_phase;
    status_led_pkg::status_flags_t prev_flags;
    logic [status_led_pkg::LED_W-1:0] wide_led;
    logic [status_led_pkg::LED_W-1:0] narrow_led;

    // Register decode
    wire hit_ctrl = addr == status_led_pkg::REG_CTRL;
    wire hit_stretch = addr == status_led_pkg::REG_STRETCH;
    wire hit_flags = addr == status_led_pkg::REG_FLAGS;
    wire hit_events = addr == status_led_pkg::REG_EVENTS;
    wire hit_mask = addr == status_led_pkg::REG_MASK;
    wire hit_leds = addr == status_led_pkg::REG_LEDS;
    wire events_read = rd && hit_events;

    // Blink rate divider
    wire blink_tick = blink_cnt == status_led_pkg::BLINK_CNT_W'(BLINK_HALF_CYCLES - 1);
    wire [status_led_pkg::BLINK_CNT_W-1:0] next_blink_cnt =
        blink_tick ? '0 : blink_cnt + status_led_pkg::BLINK_CNT_W'(1);

    // Activity stretchers
    wire [status_led_pkg::STRETCH_W-1:0] next_tx_cnt =
        next_stretch(flags.tx_active, blink_tick, tx_cnt, stretch_len);
    wire [status_led_pkg::STRETCH_W-1:0] next_rx_cnt =
        next_stretch(flags.rx_active, blink_tick, rx_cnt, stretch_len);
    wire next_tx_phase = next_phase(flags.tx_active, blink_tick, tx_cnt, tx_phase);
    wire next_rx_phase = next_phase(flags.rx_active, blink_tick, rx_cnt, rx_phase);
    wire tx_lit = (tx_cnt != '0) && tx_phase;
    wire rx_lit = (rx_cnt != '0) && rx_phase;

    // Event detection
    wire run_ok = flags.power_good && flags.init_done;
    wire remote_or_operator_service = flags.remote_tool_service || flags.operator_interface;
    wire [status_led_pkg::EVT_W-1:0] event_set = {
        run_ok && !(prev_flags.power_good && prev_flags.init_done),
        flags.speed_100 != prev_flags.speed_100,
        !flags.host_if_ok && prev_flags.host_if_ok,
        flags.fatal_error && !prev_flags.fatal_error
    };
    wire [status_led_pkg::EVT_W-1:0] next_events =
        (events & ~(events_read ? events : '0)) | event_set;

    // Panel layouts
    always_comb begin
        wide_led = '0;
        wide_led[status_led_pkg::POS_RUN] = run_ok;
        wide_led[status_led_pkg::POS_HOST] = flags.host_if_ok;
        wide_led[status_led_pkg::POS_FN_CMD] = flags.fn_block_cmd_service;
        wide_led[status_led_pkg::POS_FAST] = flags.fast_link_service;
        wide_led[status_led_pkg::POS_REMOTE] = flags.remote_tool_service;
        wide_led[status_led_pkg::WIDE_DEDICATED] = flags.dedicated_comm_service;
        wide_led[status_led_pkg::WIDE_FAULT] = flags.fatal_error;
        wide_led[status_led_pkg::WIDE_TX] = tx_lit;
        wide_led[status_led_pkg::WIDE_RX] = rx_lit;
        wide_led[status_led_pkg::WIDE_SPEED] = flags.speed_100;
    end

    always_comb begin
        narrow_led = '0;
        narrow_led[status_led_pkg::POS_RUN] = run_ok;
        narrow_led[status_led_pkg::POS_HOST] = flags.host_if_ok;
        narrow_led[status_led_pkg::POS_FN_CMD] = flags.fn_block_cmd_service;
        narrow_led[status_led_pkg::POS_FAST] = flags.fast_link_service;
        narrow_led[status_led_pkg::POS_REMOTE] = remote_or_operator_service;
        narrow_led[status_led_pkg::NARROW_TX] = tx_lit;
        narrow_led[status_led_pkg::NARROW_RX] = rx_lit;
        narrow_led[status_led_pkg::NARROW_SPEED] = flags.speed_100;
    end

    wire [status_led_pkg::LED_W-1:0] next_led =
        narrow ? (narrow_led & ~status_led_pkg::NARROW_DARK_MASK)
               : (wide_led & ~status_led_pkg::WIDE_DARK_MASK);

    // Read data selection
    wire [status_led_pkg::DATA_W-1:0] read_value =
        hit_ctrl ? status_led_pkg::DATA_W'(narrow) :
        hit_stretch ? status_led_pkg::DATA_W'(stretch_len) :
        hit_flags ? status_led_pkg::DATA_W'(flags) :
        hit_events ? status_led_pkg::DATA_W'(events) :
        hit_mask ? status_led_pkg::DATA_W'(mask) :
        hit_leds ? status_led_pkg::DATA_W'(led) : '0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            narrow <= status_led_pkg::CTRL_RESET;
        end else if (wr && hit_ctrl) begin
            narrow <= wdata[status_led_pkg::CTRL_NARROW_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stretch_len <= status_led_pkg::STRETCH_RESET;
        end else if (wr && hit_stretch) begin
            stretch_len <= wdata[status_led_pkg::STRETCH_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask <= status_led_pkg::MASK_RESET;
        end else if (wr && hit_mask) begin
            mask <= wdata[status_led_pkg::EVT_W-1:0];
        end
    end

    // Sticky events, set wins over read clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            events <= status_led_pkg::EVT_RESET;
        end else begin
            events <= next_events;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= (next_events & mask) != '0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_flags <= '0;
        end else begin
            prev_flags <= flags;
        end
    end

    // Read data stands one cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? read_value : '0;
        end
    end

    // Blink divider
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blink_cnt <= '0;
        end else begin
            blink_cnt <= next_blink_cnt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_cnt <= '0;
            tx_phase <= 1'b0;
        end else begin
            tx_cnt <= next_tx_cnt;
            tx_phase <= next_tx_phase;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_cnt <= '0;
            rx_phase <= 1'b0;
        end else begin
            rx_cnt <= next_rx_cnt;
            rx_phase <= next_rx_phase;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            led <= '0;
        end else begin
            led <= next_led;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    run_led_a: assert property (led[status_led_pkg::POS_RUN] == $past(run_ok))
        else $error("run indicator does not follow power and init");
    host_led_a: assert property (flags.host_if_ok != $past(flags.host_if_ok)
        |=> led[status_led_pkg::POS_HOST] == $past(flags.host_if_ok))
        else $error("host interface indicator wrong");
    fn_cmd_led_a: assert property (flags.fn_block_cmd_service |=> led[status_led_pkg::POS_FN_CMD])
        else $error("command service indicator not lit");
    fast_led_a: assert property (!flags.fast_link_service |=> !led[status_led_pkg::POS_FAST])
        else $error("fast link indicator lit while stopped");
    remote_wide_a: assert property (!narrow && !flags.remote_tool_service && flags.operator_interface
        |=> !led[status_led_pkg::POS_REMOTE])
        else $error("wide remote indicator merged with operator service");
    dedicated_wide_a: assert property (!narrow |=>
        led[status_led_pkg::WIDE_DEDICATED] == $past(flags.dedicated_comm_service))
        else $error("dedicated service indicator wrong");
    merged_narrow_a: assert property (narrow && (flags.remote_tool_service ^ flags.operator_interface)
        |=> led[status_led_pkg::POS_REMOTE])
        else $error("narrow merged indicator not lit");
    fault_wide_a: assert property (!narrow |=>
        led[status_led_pkg::WIDE_FAULT] == $past(flags.fatal_error))
        else $error("fault indicator wrong");
    tx_blink_a: assert property ($rose(flags.tx_active) && tx_cnt == '0 && stretch_len != '0
        ##1 !narrow |=> led[status_led_pkg::WIDE_TX])
        else $error("transmit indicator did not light on activity");
    rx_blink_a: assert property (narrow && flags.rx_active && rx_cnt == '0
        |=> ##1 led[status_led_pkg::NARROW_RX] || !narrow)
        else $error("receive indicator did not light on activity");
    speed_led_a: assert property (narrow |=>
        led[status_led_pkg::NARROW_SPEED] == $past(flags.speed_100))
        else $error("speed indicator wrong");
    dark_wide_a: assert property (!narrow |=> (led & status_led_pkg::WIDE_DARK_MASK) == '0)
        else $error("unassigned wide position lit");
    idle_dark_a: assert property (tx_cnt == '0 && !flags.tx_active && !narrow
        |=> !led[status_led_pkg::WIDE_TX])
        else $error("transmit indicator lit while idle");

    // Layout and activity
    fn_cmd_off_a: assert property (!flags.fn_block_cmd_service |=> !led[status_led_pkg::POS_FN_CMD])
        else $error("command service indicator lit while stopped");
    fast_on_a: assert property (flags.fast_link_service |=> led[status_led_pkg::POS_FAST])
        else $error("fast link indicator dark while running");
    remote_on_a: assert property (!narrow && flags.remote_tool_service |=> led[status_led_pkg::POS_REMOTE])
        else $error("wide remote indicator dark while running");
    narrow_dark_a: assert property (narrow |=> (led & status_led_pkg::NARROW_DARK_MASK) == '0)
        else $error("unassigned narrow position lit");
    merged_idle_a: assert property (narrow && !flags.remote_tool_service && !flags.operator_interface
        |=> !led[status_led_pkg::POS_REMOTE])
        else $error("narrow merged indicator lit while both stopped");
    tx_narrow_a: assert property ($rose(flags.tx_active) && tx_cnt == '0 ##1 narrow
        |=> led[status_led_pkg::NARROW_TX])
        else $error("narrow transmit indicator did not light on activity");
    rx_wide_a: assert property (!narrow && flags.rx_active && rx_cnt == '0
        |=> ##1 led[status_led_pkg::WIDE_RX] || narrow)
        else $error("wide receive indicator did not light on activity");
    tx_stretch_a: assert property (flags.tx_active |=> tx_cnt != '0)
        else $error("transmit stretch not loaded");
    rx_stretch_a: assert property (flags.rx_active |=> rx_cnt != '0)
        else $error("receive stretch not loaded");
    stretch_end_a: assert property (!flags.tx_active && blink_tick
        && tx_cnt == status_led_pkg::STRETCH_W'(1) |=> tx_cnt == '0)
        else $error("transmit stretch did not expire");
    rx_idle_a: assert property (rx_cnt == '0 && !flags.rx_active
        |=> !led[status_led_pkg::WIDE_RX] && !led[status_led_pkg::NARROW_RX])
        else $error("receive indicator lit while idle");

    // Sticky events and interrupt
    run_event_a: assert property ($rose(run_ok) |=> events[status_led_pkg::EVT_INIT])
        else $error("run event not recorded");
    host_event_a: assert property ($past(nrst) && $fell(flags.host_if_ok)
        |=> events[status_led_pkg::EVT_HOST_LOST])
        else $error("host loss event not recorded");
    speed_event_a: assert property ($past(nrst) && $changed(flags.speed_100)
        |=> events[status_led_pkg::EVT_SPEED])
        else $error("speed change event not recorded");
    fatal_event_a: assert property ($rose(flags.fatal_error) |=> events[status_led_pkg::EVT_FATAL])
        else $error("fatal event not recorded");
    read_clear_a: assert property (events_read && !flags.fatal_error
        |=> !events[status_led_pkg::EVT_FATAL])
        else $error("event read did not clear the fatal bit");
    read_data_a: assert property (events_read
        |=> rdata == status_led_pkg::DATA_W'($past(events)))
        else $error("event read returned wrong data");
    irq_level_a: assert property (irq == ((events & $past(mask)) != '0))
        else $error("interrupt level does not follow masked events");

    tx_blink_c: cover property (flags.tx_active ##1 tx_lit ##[1:1000] !tx_lit);
    merged_c: cover property (narrow && flags.operator_interface ##1 led[status_led_pkg::POS_REMOTE]);
    irq_raise_c: cover property ($rose(irq));
    read_clear_c: cover property (events_read && events != '0 ##1 events == '0);
    narrow_tx_c: cover property (narrow && tx_lit);

endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench for the status indicator driver
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam int HALF = 8;
    localparam logic [11:0] FV [11] = '{12'h800, 12'hc00, 12'h200, 12'h100, 12'h080, 12'h040,
        12'h020, 12'h010, 12'h008, 12'h001, 12'hff9};
    localparam logic [15:0] WIDE_EXP [11] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0010, 16'h0020, 16'h0000, 16'h0080, 16'h8000, 16'h80bf};
    localparam logic [15:0] NARROW_EXP [11] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0010, 16'h0000, 16'h0010, 16'h0000, 16'h0080, 16'h009f};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    status_led_pkg::status_flags_t flags = '0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic [15:0] led;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rv;
    int ones;

    status_led_indicator #(.BLINK_HALF_CYCLES(HALF)) status_led_indicator_i (.clk(clk), .nrst(nrst),
        .flags(flags), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .led(led));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic set_flags(input logic [11:0] v);
        @(posedge clk);
        flags <= status_led_pkg::status_flags_t'(v);
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input logic [11:0] v, input int bitpos);
        @(posedge clk);
        flags <= status_led_pkg::status_flags_t'(v);
        @(posedge clk);
        flags <= '0;
        @(posedge clk);
        #1;
        check({31'h0, led[bitpos]}, 32'h1);
        repeat (3 * HALF + 4) @(posedge clk);
        #1;
        check({31'h0, led[bitpos]}, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        check({16'h0, led}, 32'h0);
        check({31'h0, irq}, 32'h0);
        rd_reg(status_led_pkg::REG_CTRL, rv);
        check(rv, 32'h0);
        rd_reg(status_led_pkg::REG_STRETCH, rv);
        check(rv, 32'h4);
        rd_reg(status_led_pkg::REG_MASK, rv);
        check(rv, 32'h0);
        rd_reg(status_led_pkg::REG_EVENTS, rv);
        check(rv, 32'h0);
        rd_reg(8'h20, rv);
        check(rv, 32'h0);
        // Wide panel layout, single flags, power with init, then all flags but tx_active and rx_active
        for (int i = 0; i < 11; i++) begin
            set_flags(FV[i]);
            check({16'h0, led}, {16'h0, WIDE_EXP[i]});
        end
        wr_reg(status_led_pkg::REG_FLAGS, 32'h0);
        rd_reg(status_led_pkg::REG_FLAGS, rv);
        check(rv, 32'hff9);
        rd_reg(status_led_pkg::REG_LEDS, rv);
        check(rv, 32'h80bf);
        // Transmit and receive pulses stretched on the wide panel
        set_flags(12'h000);
        wr_reg(status_led_pkg::REG_STRETCH, 32'h1);
        pulse(12'h004, status_led_pkg::WIDE_TX);
        pulse(12'h002, status_led_pkg::WIDE_RX);
        // Continuous traffic blinks
        wr_reg(status_led_pkg::REG_STRETCH, 32'h4);
        @(posedge clk);
        flags <= status_led_pkg::status_flags_t'(12'h004);
        ones = 0;
        repeat (48) begin
            @(posedge clk);
            #1;
            ones += int'(led[status_led_pkg::WIDE_TX]);
        end
        check({31'h0, ones > 0 && ones < 48}, 32'h1);
        set_flags(12'h000);
        repeat (6 * HALF) @(posedge clk);
        #1;
        check({16'h0, led}, 32'h0);
        // Narrow panel layout
        wr_reg(status_led_pkg::REG_CTRL, 32'hffffffff);
        rd_reg(status_led_pkg::REG_CTRL, rv);
        check(rv, 32'h1);
        for (int i = 0; i < 11; i++) begin
            set_flags(FV[i]);
            check({16'h0, led}, {16'h0, NARROW_EXP[i]});
        end
        set_flags(12'h000);
        wr_reg(status_led_pkg::REG_STRETCH, 32'h1);
        pulse(12'h004, status_led_pkg::NARROW_TX);
        pulse(12'h002, status_led_pkg::NARROW_RX);
        wr_reg(status_led_pkg::REG_STRETCH, 32'h0);
        pulse(12'h004, status_led_pkg::NARROW_TX);
        // Sticky events, mask and interrupt
        rd_reg(status_led_pkg::REG_EVENTS, rv);
        wr_reg(status_led_pkg::REG_MASK, 32'h1);
        set_flags(12'h008);
        check({31'h0, irq}, 32'h1);
        wr_reg(status_led_pkg::REG_MASK, 32'h2);
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0);
        rd_reg(status_led_pkg::REG_EVENTS, rv);
        check(rv, 32'h1);
        rd_reg(status_led_pkg::REG_EVENTS, rv);
        check(rv, 32'h0);
        set_flags(12'h200);
        set_flags(12'h000);
        check({31'h0, irq}, 32'h1);
        rd_reg(status_led_pkg::REG_EVENTS, rv);
        check(rv, 32'h2);
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0);
        end_of_test();
    end
endmodule

`default_nettype wire
